// file: verilog/spd_ctrl_port.sv
// Serial and parallel control port of a six-channel low-side gate predriver
`timescale 1ns/1ps
`include "spd_map.svh"
module spd_ctrl_port import spd_pkg::*; #(
    parameter int RETRY_PERIOD_CYC = `SPD_PERIOD_CYC,
    parameter int LOG_DEPTH = 8
) (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst_b,
    // Serial link pins
    input wire logic i_sclk,
    input wire logic i_cs_b,
    input wire logic i_sdi,
    output logic o_sdo,
    output logic o_sdo_oe,
    // Parallel control and channel sense
    input wire logic [5:0] i_parallel_channel_in,
    input wire logic [5:0] i_drain_sense_in,
    // Battery monitors and variant select
    input wire logic i_bat_over,
    input wire logic i_bat_under,
    input wire logic i_retry_mode,
    // Gate drives
    output logic [5:0] o_gate_drive_out,
    // Open-drain fault flag
    output logic o_fault_flag_n_o,
    output logic o_fault_flag_n_oe,
    // Fault word log stream
    output logic o_flog_valid,
    output logic [8:0] o_flog_data,
    input wire logic i_flog_ready,
    output logic o_flog_space,
    output logic o_flog_drop
);
    localparam logic [10:0] MASK_C = 11'(`SPD_MASK_CYC);
    localparam logic [7:0] DEGL_LAST = 8'(`SPD_DEGL_CYC - 1);
    localparam logic [10:0] PULSE_C = 11'(`SPD_PULSE_CYC);
    localparam logic [19:0] PER_LAST = 20'(RETRY_PERIOD_CYC - 1);
    // Start masked: synchronisers read drain low while flushing, which looks like open load
    localparam spd_chan_s CH_RST = '{mask: MASK_C, default: '0};
    localparam spd_state_s ST_RST = '{ch: {`SPD_NCH{CH_RST}}, default: '0};

    spd_pins_s raw;
    spd_pins_s pin;
    logic [$bits(spd_pins_s)-1:0] pin_bits;
    spd_state_s state_r;
    spd_state_s state_nxt;

    logic cs_fall;
    logic cs_rise;
    logic sclk_rise;
    logic sclk_fall;
    logic bat_fault;
    logic [5:0] cmd;
    logic [5:0] masked;
    logic [5:0] open_f;
    logic [5:0] load_f;
    logic [5:0] gate_n;
    spd_fword_t fword;
    logic [7:0] tx_byte;

    assign raw = '{
        sclk: i_sclk,
        cs_b: i_cs_b,
        sdi: i_sdi,
        bat_over: i_bat_over,
        bat_under: i_bat_under,
        retry_mode: i_retry_mode,
        par: i_parallel_channel_in,
        drain: i_drain_sense_in
    };

    // Every pin, including the serial clock, goes through the same two flops
    spd_sync2 #(
        .W($bits(spd_pins_s))
    ) u_sync (
        .i_clk(i_core_clk),
        .i_rst_b(i_rst_b),
        .i_d(raw),
        .o_q(pin_bits)
    );

    assign pin = spd_pins_s'(pin_bits);

    always_comb begin
        state_nxt = state_r;
        state_nxt.prev = pin;

        cs_fall = state_r.prev.cs_b & ~pin.cs_b;
        cs_rise = ~state_r.prev.cs_b & pin.cs_b;
        // Clock edges only count while selected
        sclk_rise = ~state_r.prev.sclk & pin.sclk & ~pin.cs_b;
        sclk_fall = state_r.prev.sclk & ~pin.sclk & ~pin.cs_b;
        bat_fault = pin.bat_over | pin.bat_under;

        cmd = '0;
        masked = '0;
        open_f = '0;
        load_f = '0;
        gate_n = '0;

        for (int i = 0; i < `SPD_NCH; i++) begin
            cmd[i] = state_r.ctrl[i] | pin.par[i];
            state_nxt.ch[i].cmd = cmd[i];
            masked[i] = (state_r.ch[i].mask != '0);

            // Short: gate on, unmasked, drain high for the whole deglitch time
            if (state_r.ch[i].gate && !masked[i] && pin.drain[i] && !state_r.ch[i].short_f) begin
                if (state_r.ch[i].degl == DEGL_LAST) begin
                    state_nxt.ch[i].short_f = 1'b1;
                    state_nxt.ch[i].degl = '0;
                    state_nxt.ch[i].per = '0;
                    state_nxt.ch[i].pulse = '0;
                end else begin
                    state_nxt.ch[i].degl = state_r.ch[i].degl + 8'h01;
                end
            end else begin
                state_nxt.ch[i].degl = '0;
            end

            // Retry pulses while faulted; a quiet drain inside a pulse ends the fault
            if (state_r.ch[i].short_f && pin.retry_mode) begin
                if (state_r.ch[i].pulse != '0) begin
                    state_nxt.ch[i].pulse = state_r.ch[i].pulse - 11'h001;
                end
                if (state_r.ch[i].per == PER_LAST) begin
                    state_nxt.ch[i].per = '0;
                    state_nxt.ch[i].pulse = PULSE_C;
                end else begin
                    state_nxt.ch[i].per = state_r.ch[i].per + 20'h00001;
                end
                if (state_r.ch[i].pulse != '0 && !masked[i] && !pin.drain[i]) begin
                    state_nxt.ch[i].short_f = 1'b0;
                    state_nxt.ch[i].pulse = '0;
                end
            end

            // Off-to-on command edge from either source clears a latched short
            if ((cmd[i] && !state_r.ch[i].cmd) || (pin.retry_mode && !cmd[i])) begin
                state_nxt.ch[i].short_f = 1'b0;
                state_nxt.ch[i].per = '0;
                state_nxt.ch[i].pulse = '0;
            end

            // Battery faults force every gate off
            gate_n[i] = cmd[i] & ~bat_fault
                & (~state_nxt.ch[i].short_f
                | (pin.retry_mode & (state_nxt.ch[i].pulse != '0)));
            state_nxt.ch[i].gate = gate_n[i];

            if (gate_n[i] != state_r.ch[i].gate) begin
                state_nxt.ch[i].mask = MASK_C;
            end else if (masked[i]) begin
                state_nxt.ch[i].mask = state_r.ch[i].mask - 11'h001;
            end

            // Open load is live only: gate off, unmasked, drain pulled low
            open_f[i] = ~state_r.ch[i].gate & ~masked[i] & ~pin.drain[i];
            load_f[i] = (state_r.ch[i].short_f | open_f[i]) & ~bat_fault;
        end

        fword = '0;
        fword[5:0] = load_f;
        fword[`SPD_FW_UV] = pin.bat_under;
        fword[`SPD_FW_OV] = pin.bat_over;
        // Eight bits on the wire: word bit 6 is never used and is dropped
        tx_byte = {fword[`SPD_FW_OV], fword[`SPD_FW_UV], fword[5:0]};

        // One shift register carries fault data out and command data in
        if (cs_fall) begin
            state_nxt.shreg = tx_byte;
            state_nxt.sdo = tx_byte[`SPD_FRAME_BITS-1];
        end else if (sclk_rise) begin
            state_nxt.shreg = {state_r.shreg[6:0], pin.sdi};
        end else if (sclk_fall) begin
            state_nxt.sdo = state_r.shreg[`SPD_FRAME_BITS-1];
        end

        // Frames under six clocks leave fault residue in the low six bits; that is what loads
        if (cs_rise) begin
            state_nxt.ctrl = state_r.shreg[`SPD_CMD_LSB +: `SPD_NCH];
            state_nxt.shreg = '0;
        end

        // A new fault in the cs-fall cycle keeps the flag set
        state_nxt.fault_flag_n = (|fword) | (state_r.fault_flag_n & ~cs_fall);
        state_nxt.drop = state_r.drop | (cs_fall & ~o_flog_space);
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            state_r <= ST_RST;
        end else begin
            state_r <= state_nxt;
        end
    end

    for (genvar g = 0; g < `SPD_NCH; g++) begin : g_gate
        assign o_gate_drive_out[g] = state_r.ch[g].gate;
    end

    assign o_sdo = state_r.sdo;
    assign o_sdo_oe = ~state_r.prev.cs_b;
    assign o_fault_flag_n_o = 1'b0;
    assign o_fault_flag_n_oe = state_r.fault_flag_n;
    assign o_flog_drop = state_r.drop;

    // Each captured fault word is also queued for on-chip observers, except one captured while the log is full, which is dropped
    spd_fifo #(
        .W($bits(spd_fword_t)),
        .DEPTH(LOG_DEPTH)
    ) u_log (
        .i_clk(i_core_clk),
        .i_rst_b(i_rst_b),
        .i_valid(cs_fall),
        .i_data(fword),
        .o_ready(o_flog_space),
        .o_valid(o_flog_valid),
        .o_data(o_flog_data),
        .i_ready(i_flog_ready)
    );
endmodule : spd_ctrl_port

// file: verilog/spd_map.svh
// Offsets, field positions, reset values and timing counts of the predriver control port
// Notes on behaviour
// - After chip select falls, each rising serial clock shifts data-in into the LSB.
// - Shift register is eight bits; first bit reaches MSB after eight clocks.
// - Fewer than eight clocks leaves residual fault data loaded as the command; here six or seven clocks load only received bits.
// - First two received bits ignored; last six are per-channel control bits.
// - Rising chip select copies the shift register into the output control register.
// - Control bit zero turns its gate off; one turns it on.
// - Serial output changes only at chip select fall and on falling serial clock edges.
// - Fault MSB appears at chip select fall; seven more bits follow on clocks.
// - Fault status is captured at chip select fall; vanished faults are not captured.
// - Chip select high: output released, input ignored; rise latches, clears, re-arms.
// - Latch-off: short shutdown holds until channel toggled off and on, clearing fault.
// - Retry variant retries automatically and releases the flag once short disappears; here the flag holds until the next chip select fall.
// - Gate is on when parallel input or serial control bit commands on.
// - Parallel inputs act on gates in real time, without serial activity.
// - Short-disabled gate re-enables when its parallel input goes low then high.
// - Every gate transition masks short and open evaluation for 60 microseconds.
// - Retry variant: 68 microsecond gate pulses every 10 milliseconds while faulted and commanded.
// - After mask, short declared when drain stays high for deglitch time; latch-off shuts gate.
// - Fault word bits 0 to 5 report the load fault of channels 0 to 5.
// - Bit 8 overvoltage, bit 7 undervoltage; load faults suppressed during battery fault.
// - Fault flag releases at chip select fall unless another fault is present.
`ifndef SPD_MAP_SVH
`define SPD_MAP_SVH

`define SPD_CLK_NS 50
`define SPD_NCH 6
`define SPD_FRAME_BITS 8
`define SPD_CMD_LSB 0
`define SPD_FW_UV 7
`define SPD_FW_OV 8
`define SPD_CTRL_RST 6'h00

`define SPD_MASK_NS 60000
`define SPD_DEGL_NS 8000
`define SPD_PULSE_NS 68000
`define SPD_PERIOD_NS 10000000
`define SPD_MASK_CYC ((`SPD_MASK_NS + `SPD_CLK_NS - 1) / `SPD_CLK_NS)
`define SPD_DEGL_CYC ((`SPD_DEGL_NS + `SPD_CLK_NS - 1) / `SPD_CLK_NS)
`define SPD_PULSE_CYC ((`SPD_PULSE_NS + `SPD_CLK_NS - 1) / `SPD_CLK_NS)
`define SPD_PERIOD_CYC ((`SPD_PERIOD_NS + `SPD_CLK_NS - 1) / `SPD_CLK_NS)

`endif

// file: verilog/spd_pkg.sv
// Types shared by the predriver control port
package spd_pkg;

    // Pin inputs after synchronisation
    typedef struct packed {
        logic sclk;
        logic cs_b;
        logic sdi;
        logic bat_over;
        logic bat_under;
        logic retry_mode;
        logic [5:0] par;
        logic [5:0] drain;
    } spd_pins_s;

    // Per-channel timing and fault state
    typedef struct packed {
        logic [10:0] mask;
        logic [7:0] degl;
        logic [19:0] per;
        logic [10:0] pulse;
        logic short_f;
        logic gate;
        logic cmd;
    } spd_chan_s;

    typedef struct packed {
        spd_pins_s prev;
        logic [7:0] shreg;
        logic [5:0] ctrl;
        logic sdo;
        logic fault_flag_n;
        logic drop;
        spd_chan_s [5:0] ch;
    } spd_state_s;

    typedef logic [8:0] spd_fword_t;

endpackage : spd_pkg

// file: verilog/spd_sync2.sv
// Two-flop synchroniser for a bundle of pin inputs
`timescale 1ns/1ps
module spd_sync2 #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_b,
    // Data
    input wire logic [W-1:0] i_d,
    output logic [W-1:0] o_q
);
    logic [W-1:0] meta_r;
    logic [W-1:0] q_r;

    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            meta_r <= '0;
            q_r <= '0;
        end else begin
            meta_r <= i_d;
            q_r <= meta_r;
        end
    end

    assign o_q = q_r;
endmodule : spd_sync2

// file: verilog/spd_fifo.sv
// Parameterised valid/ready FIFO
`timescale 1ns/1ps
module spd_fifo #(
    parameter int W = 9,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_b,
    // Fill side
    input wire logic i_valid,
    input wire logic [W-1:0] i_data,
    output logic o_ready,
    // Drain side
    output logic o_valid,
    output logic [W-1:0] o_data,
    input wire logic i_ready
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);
    localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] wr_r;
    logic [AW-1:0] rd_r;
    logic [AW:0] cnt_r;
    logic push;
    logic pop;

    assign o_ready = (cnt_r != FULL);
    assign o_valid = (cnt_r != '0);
    assign push = i_valid & o_ready;
    assign pop = o_valid & i_ready;
    assign o_data = mem[rd_r];

    always_ff @(posedge i_clk) begin
        if (push) begin
            mem[wr_r] <= i_data;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            wr_r <= '0;
            rd_r <= '0;
            cnt_r <= '0;
        end else begin
            if (push) begin
                wr_r <= (wr_r == LAST) ? '0 : wr_r + 1'b1;
            end
            if (pop) begin
                rd_r <= (rd_r == LAST) ? '0 : rd_r + 1'b1;
            end
            if (push && !pop) begin
                cnt_r <= cnt_r + 1'b1;
            end else if (pop && !push) begin
                cnt_r <= cnt_r - 1'b1;
            end
        end
    end
endmodule : spd_fifo

// file: verif/spd_ctrl_port_properties.sv
// Pin-level assertions of the predriver control port
`timescale 1ns/1ps
module spd_ctrl_props (
    // Clock, reset and serial
    input wire logic i_core_clk,
    input wire logic i_rst_b,
    input wire logic i_cs_b,
    input wire logic o_sdo_oe,
    // Channels and flag
    input wire logic [5:0] i_parallel_channel_in,
    input wire logic i_bat_over,
    input wire logic i_bat_under,
    input wire logic [5:0] o_gate_drive_out,
    input wire logic o_fault_flag_n_o,
    input wire logic o_fault_flag_n_oe,
    // Fault log
    input wire logic o_flog_valid,
    input wire logic [8:0] o_flog_data,
    input wire logic i_flog_ready
);
    default clocking @(posedge i_core_clk);
    endclocking
    default disable iff (!i_rst_b);
    wire bat = i_bat_over | i_bat_under;
    wire on0 = i_parallel_channel_in[0] & ~bat;
    // Pins pass three flops, so six samples cover the lag
    sequence s_gate0_up;
        $rose(o_gate_drive_out[0]) ##0 on0;
    endsequence
    a_sdo_released: assert property (i_cs_b [*6] |-> !o_sdo_oe)
        else $error("sdo driven with chip select high");
    a_sdo_driven: assert property (!i_cs_b [*6] |-> o_sdo_oe)
        else $error("sdo released with chip select low");
    a_bat_gates_off: assert property (bat [*6] |-> o_gate_drive_out == 6'h00)
        else $error("gate on during battery fault");
    a_bat_flag_set: assert property (bat [*6] |-> o_fault_flag_n_oe)
        else $error("flag idle during battery fault");
    a_flag_pulls_low: assert property (o_fault_flag_n_oe |-> !o_fault_flag_n_o)
        else $error("flag not pulled low");
    a_par_gate_on: assert property (
        (on0 && !o_fault_flag_n_oe) [*6] |-> o_gate_drive_out[0] or ##[1:4] o_fault_flag_n_oe)
        else $error("parallel input did not turn gate on");
    a_mask_hold: assert property (s_gate0_up ##1 on0 [*8] |-> o_gate_drive_out[0])
        else $error("gate dropped inside mask time");
    a_log_hold: assert property (o_flog_valid && !i_flog_ready
        |=> o_flog_valid && $stable(o_flog_data))
        else $error("log head changed while stalled");
endmodule : spd_ctrl_props
bind spd_ctrl_port spd_ctrl_props spd_ctrl_props_i (.i_core_clk, .i_rst_b, .i_cs_b, .o_sdo_oe,
    .i_parallel_channel_in, .i_bat_over, .i_bat_under, .o_gate_drive_out, .o_fault_flag_n_o,
    .o_fault_flag_n_oe, .o_flog_valid, .o_flog_data, .i_flog_ready);

// file: verif/spd_host_model.sv
// Host controller model on the serial link
`timescale 1ns/1ps
module spd_host_model (
    // Serial link
    output logic o_sclk = 1'b0,
    output logic o_cs_b = 1'b1,
    output logic o_sdi = 1'b0,
    input wire logic i_sdo
);
    // Sdi moves mid-low so it never races the rise; clock idles low
    task automatic frame(input logic [7:0] tx, input int n, output logic [7:0] rx);
        rx = 8'h00;
        o_cs_b = 1'b0;
        #400;
        for (int k = 0; k < n; k++) begin
            o_sdi = tx[7-k];
            #100 o_sclk = 1'b1;
            #199 rx = {rx[6:0], i_sdo};
            #1 o_sclk = 1'b0;
            #100;
        end
        o_cs_b = 1'b1;
        o_sdi = ~o_sdi;
        #800;
    endtask : frame
endmodule : spd_host_model

// file: verif/test_six_channel_predriver_ctrl_port.sv
// Self-checking bench of the predriver control port
`timescale 1ns/1ps
module test_six_channel_predriver_ctrl_port;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [5:0] par = 6'h00;
    logic [5:0] inj = 6'h00;
    logic bov = 1'b0;
    logic buv = 1'b0;
    logic retry = 1'b0;
    logic frdy = 1'b1;
    logic sclk, cs_b, sdi, sdo, sdo_oe, flt_o, fault_flag_n, fv, fsp, fdrop;
    logic [5:0] gate;
    logic [8:0] fdata;
    logic [7:0] rx;
    int miscompares = 0;
    int checks_done = 0;
    int cyc = 0;
    // Load model: drain low while on, forced high by an injected short
    wire [5:0] drain = ~gate | inj;
    always #25 clk = ~clk;
    spd_host_model spd_host_model_i (.o_sclk(sclk), .o_cs_b(cs_b), .o_sdi(sdi), .i_sdo(sdo));
    spd_ctrl_port #(.RETRY_PERIOD_CYC(3000)) spd_ctrl_port_i (.i_core_clk(clk), .i_rst_b(rst_b),
        .i_sclk(sclk), .i_cs_b(cs_b), .i_sdi(sdi), .o_sdo(sdo), .o_sdo_oe(sdo_oe),
        .i_parallel_channel_in(par), .i_drain_sense_in(drain), .i_bat_over(bov),
        .i_bat_under(buv), .i_retry_mode(retry), .o_gate_drive_out(gate),
        .o_fault_flag_n_o(flt_o), .o_fault_flag_n_oe(fault_flag_n), .o_flog_valid(fv),
        .o_flog_data(fdata), .i_flog_ready(frdy), .o_flog_space(fsp), .o_flog_drop(fdrop));
    task automatic chk(input string what, input logic [8:0] exp, input logic [8:0] got);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : report_and_stop
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask : tick
    task automatic wait_gate(input int ch, input logic v, output int n);
        n = 0;
        while (gate[ch] !== v && n < 5000) begin
            @(negedge clk);
            n++;
        end
    endtask : wait_gate
    task automatic xfer(input logic [7:0] tx, input int bits);
        spd_host_model_i.frame(tx, bits, rx);
        tick(8);
    endtask : xfer
    task automatic t_serial;
        xfer(8'hEA, 8);
        chk("fault byte", 9'h000, 9'(rx));
        chk("gates", 9'h02A, 9'(gate));
        xfer(8'hA0, 3);
        chk("gates", 9'h005, 9'(gate));
        par = 6'h11;
        tick(8);
        chk("gates", 9'h015, 9'(gate));
        xfer(8'h00, 8);
        chk("gates", 9'h011, 9'(gate));
        $display("t_serial done");
    endtask : t_serial
    task automatic t_battery;
        par = 6'h01;
        for (int i = 0; i < 3; i++) begin
            {bov, buv} = 2'b10 >> i;
            tick(10);
            chk("gates", 9'(i == 2), 9'(gate));
            xfer(8'h00, 8);
            chk("fault byte", 9'((i < 2) ? 8'h80 >> i : 8'h00), 9'(rx));
            chk("flag", 9'(i < 2), 9'(fault_flag_n));
        end
        par = 6'h00;
        tick(8);
        $display("t_battery done");
    endtask : t_battery
    task automatic t_latch;
        int n;
        inj = 6'h01;
        par = 6'h01;
        wait_gate(0, 1'b1, n);
        wait_gate(0, 1'b0, n);
        chk("short delay", 9'h001, 9'(n >= 1358 && n <= 1366));
        tick(500);
        chk("gates", 9'h000, 9'(gate));
        xfer(8'h00, 8);
        chk("fault byte", 9'h001, 9'(rx));
        inj = 6'h00;
        par = 6'h00;
        tick(10);
        par = 6'h01;
        tick(10);
        chk("gates", 9'h001, 9'(gate));
        xfer(8'h00, 8);
        chk("flag", 9'h000, 9'(fault_flag_n));
        par = 6'h00;
        $display("t_latch done");
    endtask : t_latch
    task automatic t_retry;
        int n;
        int w;
        retry = 1'b1;
        inj = 6'h02;
        par = 6'h02;
        wait_gate(1, 1'b1, n);
        wait_gate(1, 1'b0, n);
        wait_gate(1, 1'b1, n);
        wait_gate(1, 1'b0, w);
        inj = 6'h00;
        wait_gate(1, 1'b1, n);
        chk("pulse", 9'h001, 9'(w >= 1355 && w <= 1365));
        chk("period", 9'h001, 9'(w + n >= 2995 && w + n <= 3005));
        tick(1500);
        chk("gates", 9'h002, 9'(gate));
        xfer(8'h00, 8);
        chk("flag", 9'h000, 9'(fault_flag_n));
        par = 6'h00;
        retry = 1'b0;
        $display("t_retry done");
    endtask : t_retry
    task automatic t_fifo;
        int k;
        k = 0;
        frdy = 1'b0;
        buv = 1'b1;
        for (int i = 0; i < 9; i++) begin
            spd_host_model_i.frame(8'h00, 0, rx);
            chk("log space", 9'(i < 7), 9'(fsp));
        end
        chk("log drop", 9'h001, 9'(fdrop));
        tick(1);
        frdy = 1'b1;
        repeat (12) begin
            if (fv === 1'b1) begin
                k++;
                chk("log word", 9'h080, fdata);
            end
            @(negedge clk);
        end
        chk("log count", 9'h008, 9'(k));
        buv = 1'b0;
        $display("t_fifo done");
    endtask : t_fifo
    initial begin
        tick(9);
        rst_b = 1'b1;
        tick(6);
        t_serial;
        t_battery;
        t_latch;
        t_retry;
        t_fifo;
        report_and_stop;
    end
    // Whole run needs about 12000 cycles
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            miscompares++;
            report_and_stop;
        end
    end
endmodule : test_six_channel_predriver_ctrl_port
